/* File: verilog/quadrature_encoder_counter.sv */
// quadrature decoder with position counter, speed gate and homing
// Operation
// - direction from which phase leads
// - count every edge of both phases
// - handle up to 250,000 counts per second
// - only the two primary phases are used
// - home at limit switch, zero there
// - speed from counts per fixed period
// - forward increments, swap reverses direction
// - limit active on phase stops counting
`include "qec_params.svh"
module quadrature_encoder_counter #(
	parameter int POS_W    = 32,
	parameter int SPD_W    = 16,
	parameter int GATE_CYC = `QEC_GATE_CYC
) (
	// clock, reset, enable
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               clkEn,
	// encoder phases and limit switch flags from the pins
	input  wire logic               quadPhaseFirst,
	input  wire logic               quadPhaseSecond,
	input  wire logic               limitFirst,
	input  wire logic               limitSecond,
	input  wire logic               homeLimit,
	// control
	input  wire logic               swapPhases,
	input  wire logic               homeStart,
	// results
	output logic signed [POS_W-1:0] position,
	output logic signed [SPD_W-1:0] speed,
	output logic                    dirForward,
	output logic                    invalidSeen,
	output logic                    motorDrive,
	output logic                    homed,
	output logic                    countStopped
);
	import qec_pkg::*;

	typedef struct packed {
		logic [1:0]              prevAB;
		logic signed [POS_W-1:0] pos;
		logic signed [SPD_W-1:0] gateCnt;
		logic signed [SPD_W-1:0] spd;
		logic [31:0]             gateTmr;
		logic                    dirFwd;
		logic                    invalid;
		logic                    drive;
		logic                    stopped;
		logic                    homeReq;
		logic                    swapPrev;
		logic                    homedFlag;
		qec_home_t               home;
	} qec_state_t;
	qec_state_t st_r;
	qec_state_t st_nxt;

	logic phA;
	logic phB;
	logic limA;
	logic limB;
	logic limH;
	logic start;

	// pins pass three stages; only the two phases reach the decoder
	// first phase pin
	qec_sync uSyncA (
		.clk      (clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.pinIn    (quadPhaseFirst),
		.levelOut (phA)
	);
	// second phase pin
	qec_sync uSyncB (
		.clk      (clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.pinIn    (quadPhaseSecond),
		.levelOut (phB)
	);
	// limit switch sharing the first phase
	qec_sync uSyncLa (
		.clk      (clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.pinIn    (limitFirst),
		.levelOut (limA)
	);
	// limit switch sharing the second phase
	qec_sync uSyncLb (
		.clk      (clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.pinIn    (limitSecond),
		.levelOut (limB)
	);
	// homing limit switch
	qec_sync uSyncLh (
		.clk      (clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.pinIn    (homeLimit),
		.levelOut (limH)
	);
	// homing request, comes from outside the clock domain
	qec_sync uSyncSt (
		.clk      (clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.pinIn    (homeStart),
		.levelOut (start)
	);

	// +1, -1 or 0 for a step from old to new gray pair
	function automatic logic signed [1:0] qecStep(
		input logic [1:0] oldAB,
		input logic [1:0] newAB
	);
		logic signed [1:0] s;
		s = 2'sd0;
		case ({oldAB, newAB})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: s = 2'sd1;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: s = -2'sd1;
			default:                              s = 2'sd0;
		endcase
		return s;
	endfunction : qecStep

	logic [1:0]        curAB;
	logic signed [1:0] step;
	logic              blocked;

	// the swap control exchanges the phases and so reverses the count
	assign curAB = swapPhases ? {phB, phA} : {phA, phB};
	assign blocked = limA | limB;

	always_comb begin
		st_nxt = st_r;
		step = qecStep(st_r.prevAB, curAB);
		st_nxt.stopped = blocked;
		// a masked phase is frozen, so hold the old pair too
		if (!blocked) begin
			st_nxt.prevAB = curAB;
			// both phases moving at once cannot be ordered: flag only
			// a swap relabels the phases without motion: resync only,
			// otherwise an unequal pair would look like both phases moving and set the invalid flag
			if (swapPhases != st_r.swapPrev) begin
				st_nxt.invalid = st_r.invalid;
			end else if ((st_r.prevAB ^ curAB) == 2'b11) begin
				st_nxt.invalid = 1'b1;
			end else if (step != 2'sd0) begin
				// one count per edge; 40 cycles per count at the top rate is ample margin
				st_nxt.pos = st_r.pos + POS_W'(step);
				st_nxt.gateCnt = st_r.gateCnt + SPD_W'(step);
				st_nxt.dirFwd = (step > 0);
			end
		end
		// fixed gate: speed is counts per gate period, signed
		if (st_r.gateTmr >= 32'(GATE_CYC - 1)) begin
			st_nxt.gateTmr = '0;
			st_nxt.spd = st_r.gateCnt;
			st_nxt.gateCnt = '0;
		end else begin
			st_nxt.gateTmr = st_r.gateTmr + 32'h1;
		end
		if (blocked) begin
			st_nxt.gateCnt = st_r.gateCnt;
		end
		// homing: drive until the limit closes, then zero position
		case (st_r.home)
			QEC_IDLE: begin
				st_nxt.drive = 1'b0;
				if (start) begin
					st_nxt.home = QEC_SEEK;
				end
			end
			QEC_SEEK: begin
				st_nxt.drive = 1'b1;
				if (limH) begin
					st_nxt.drive = 1'b0;
					st_nxt.pos = POS_W'(`QEC_POS_RESET);
					st_nxt.home = QEC_HOMED;
				end
			end
			QEC_HOMED: begin
				st_nxt.drive = 1'b0;
				if (start && !limH) begin
					st_nxt.home = QEC_SEEK;
				end
			end
			default: begin
				st_nxt.home = QEC_IDLE;
				st_nxt.drive = 1'b0;
			end
		endcase
		st_nxt.homeReq = start;
		st_nxt.swapPrev = swapPhases;
		// registered copy so the output comes from a flip-flop
		st_nxt.homedFlag = (st_nxt.home == QEC_HOMED);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	// all outputs straight from the state register
	assign position     = st_r.pos;
	assign speed        = st_r.spd;
	assign dirForward   = st_r.dirFwd;
	assign invalidSeen  = st_r.invalid;
	assign motorDrive   = st_r.drive;
	assign homed        = st_r.homedFlag;
	assign countStopped = st_r.stopped;
endmodule : quadrature_encoder_counter

/* File: include/qec_params.svh */
// constants for the quadrature encoder counter
`ifndef QEC_PARAMS_SVH
`define QEC_PARAMS_SVH
`define QEC_CLK_HZ         10000000
`define QEC_MAX_COUNT_RATE 250000
// least cycles between two counts at the top rate, rounded down
`define QEC_MIN_EDGE_CYC   (`QEC_CLK_HZ / `QEC_MAX_COUNT_RATE)
// speed gate period in ms as printed, and its cycle count
`define QEC_GATE_MS        10
`define QEC_GATE_CYC       (`QEC_CLK_HZ / 1000 * `QEC_GATE_MS)
`define QEC_POS_RESET      32'h00000000
`endif

/* File: include/qec_pkg.sv */
// types for the quadrature encoder counter
package qec_pkg;
	typedef enum logic [1:0] {
		QEC_IDLE  = 2'b00,
		QEC_SEEK  = 2'b01,
		QEC_HOMED = 2'b11
	} qec_home_t;
endpackage : qec_pkg

/* File: verilog/qec_sync.sv */
// three-stage input synchroniser with agreement filter
module qec_sync (
	// clock, reset and enable
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clkEn,
	// pin in, clean level out
	input  wire logic pinIn,
	output logic      levelOut
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} qec_sync_t;
	qec_sync_t st_r;
	qec_sync_t st_nxt;

	// s1 feeds only s2; change accepted when s2 and s3 agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pinIn;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.lvl = st_r.s3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else if (clkEn) begin
			st_r <= st_nxt;
		end
	end

	assign levelOut = st_r.lvl;
endmodule : qec_sync

/* File: test/qec_encoder_model.sv */
// behavioural quadrature encoder driving the two phase pins
module qec_encoder_model (
	// clock and phase pins
	input  wire logic clk,
	output logic      phA,
	output logic      phB
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] abR = 2'h0;
	assign phA = abR[1];
	assign phB = abR[0];
	// one gray step after gap cycles; gap of 4 is the fast case
	task automatic step(input logic fwd, input int gap);
		repeat (gap) @(posedge clk);
		abR <= fwd ? {abR[0], ~abR[1]} : {~abR[0], abR[1]};
	endtask : step
	// both phases at once, only when a scenario asks for a fault
	task automatic jump();
		@(posedge clk) abR <= ~abR;
	endtask : jump
endmodule : qec_encoder_model

/* File: test/qec_asserts.sv */
// port checker for the quadrature encoder counter
module qec_asserts #(
	parameter int POS_W = 32,
	parameter int SPD_W = 16
) (
	input wire logic clk, rst_n, limitFirst, limitSecond, clkEn,
	input wire logic signed [POS_W-1:0] position,
	input wire logic signed [SPD_W-1:0] speed,
	input wire logic dirForward, invalidSeen, motorDrive, homed, countStopped
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_up; position == $past(position) + 1; endsequence
	sequence s_down; position == $past(position) - 1; endsequence
	a_step_one: assert property ($changed(position) && !$fell(motorDrive)
		|-> s_up or s_down) else $error("position jumped");
	a_dir_up: assert property (s_up ##0 !$fell(motorDrive) |-> dirForward)
		else $error("up count not forward");
	a_dir_down: assert property (s_down |-> !dirForward)
		else $error("down count marked forward");
	a_home_zero: assert property ($fell(motorDrive)
		|-> ##[0:2] (position == 0 && homed)) else $error("home");
	a_seek_nohome: assert property (motorDrive |-> !homed)
		else $error("homed while seeking");
	a_invalid_hold: assert property (invalidSeen |=> invalidSeen)
		else $error("invalid flag lost");
	a_speed_hold: assert property ($changed(speed) |=> $stable(speed)[*8])
		else $error("speed not gated");
	a_limit_stop: assert property ((clkEn && (limitFirst || limitSecond))[*8]
		|-> countStopped) else $error("limit ignored");
	a_stop_hold: assert property (countStopped[*3] |-> $stable(position))
		else $error("count while stopped");
endmodule : qec_asserts
bind quadrature_encoder_counter qec_asserts #(.POS_W(POS_W), .SPD_W(SPD_W))
	u_qec_asserts (.clk(clk), .rst_n(rst_n), .limitFirst(limitFirst),
	.limitSecond(limitSecond), .clkEn(clkEn), .position(position),
	.speed(speed), .dirForward(dirForward), .invalidSeen(invalidSeen),
	.motorDrive(motorDrive), .homed(homed), .countStopped(countStopped));

/* File: test/quadrature_encoder_counter_tb_top.sv */
// self-checking bench for the quadrature encoder counter
module quadrature_encoder_counter_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, limitFirst = 0, homeLimit = 0, phA, phB;
	logic swapPhases = 0, homeStart = 0, dirForward, invalidSeen, motorDrive;
	logic homed, countStopped, limitSecond = 0;
	logic signed [31:0] position, expPos = 0;
	logic signed [15:0] speed;
	int n_mismatch = 0, cmp_count = 0, n, r;
	integer seed = 32'h0fc2;
	always #50 clk = ~clk;
	qec_encoder_model u_qec_encoder_model (.clk(clk), .phA(phA), .phB(phB));
	// short gate keeps the speed scenario brief
	quadrature_encoder_counter #(.GATE_CYC(200)) u_quadrature_encoder_counter (
		.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .quadPhaseFirst(phA),
		.quadPhaseSecond(phB), .limitFirst(limitFirst),
		.limitSecond(limitSecond),
		.homeLimit(homeLimit), .swapPhases(swapPhases), .homeStart(homeStart),
		.position(position), .speed(speed), .dirForward(dirForward),
		.invalidSeen(invalidSeen), .motorDrive(motorDrive), .homed(homed),
		.countStopped(countStopped));
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic int stepSign(input logic fwd, swap);
		return (fwd ^ swap) ? 1 : -1;
	endfunction : stepSign
	// steps made while a limit is held must not count
	task automatic run(input int cnt, input logic fwd, input int gap);
		repeat (cnt) begin
			u_qec_encoder_model.step(fwd, gap);
			if (!(limitFirst | limitSecond))
				expPos += stepSign(fwd, swapPhases);
		end
		repeat (8) @(posedge clk);
	endtask : run
	task automatic wait_drive(input logic v);
		n = 0;
		while (motorDrive !== v) begin
			if (++n > 500) begin
				n_mismatch++;
				end_of_test();
			end
			@(posedge clk);
		end
	endtask : wait_drive
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			@(posedge clk) swapPhases <= (i == 3 || i == 4);
			run(r[3:0] + 1, r[4], 4 + r[7:5]);
			chk("position", position, expPos);
			chk("direction", dirForward, r[4] ^ swapPhases);
		end
		@(posedge clk) swapPhases <= 0;
		run(30, 1, 10);
		chk("speed sign", speed > 0, 1);
		chk("invalid", invalidSeen, 0);
		u_qec_encoder_model.jump();
		repeat (8) @(posedge clk);
		chk("invalid", invalidSeen, 1);
		chk("position", position, expPos);
		@(posedge clk) limitFirst <= 1;
		run(4, 1, 6);
		chk("stopped", countStopped, 1);
		chk("position", position, expPos);
		@(posedge clk) limitFirst <= 0;
		limitSecond <= 1;
		run(4, 0, 6);
		chk("stopped", countStopped, 1);
		chk("position", position, expPos);
		@(posedge clk) limitSecond <= 0;
		homeStart <= 1;
		wait_drive(1);
		homeStart <= 0;
		homeLimit <= 1;
		wait_drive(0);
		repeat (2) @(posedge clk);
		chk("home pos", position, 0);
		chk("homed", homed, 1);
		end_of_test();
	end
endmodule : quadrature_encoder_counter_tb_top
